// file: pkg/dtm_pkg.sv
package dtm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] DTM_ADDR_CTRL      = 4'h0;
   localparam logic [3:0] DTM_ADDR_LEVEL_STS = 4'h1;
   localparam logic [3:0] DTM_ADDR_LATCH_STS = 4'h2;
   localparam logic [3:0] DTM_ADDR_FATAL_STS = 4'h3;
   localparam logic [3:0] DTM_ADDR_HIST_CNT  = 4'h4;
   localparam logic [3:0] DTM_ADDR_HIST_RD   = 4'h5;
   localparam logic [3:0] DTM_ADDR_MFI_SEL   = 4'h6;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int DTM_CTRL_OVERLOAD_EN  = 0;
   localparam int DTM_CTRL_UNDERLOAD_EN = 1;
   localparam int DTM_CTRL_THERMAL_EN   = 2;
   localparam int DTM_CTRL_PHASE_OUT    = 3;
   localparam int DTM_CTRL_PHASE_IN     = 4;
   localparam int DTM_CTRL_FAN_ACTION   = 5;
   localparam int DTM_CTRL_DEV_EN       = 6;
   localparam int DTM_CTRL_WIRE_CHECK   = 7;
   localparam int DTM_CTRL_KEYPAD_LOSS  = 8;
   localparam int DTM_CTRL_CMD_LOSS     = 9;
   localparam int DTM_CTRL_FUSE_RATED   = 10;
   localparam int DTM_CTRL_W            = 11;
   localparam logic [DTM_CTRL_W-1:0] DTM_CTRL_RESET = 11'h000;

   // Phase setting bit positions within a phase_loss_enable_bits word
   localparam int DTM_PHASE_OUT_BIT = 1;
   localparam int DTM_PHASE_IN_BIT  = 2;

   // ----------------------------------------------------------------
   // Multi-function input codes
   // ----------------------------------------------------------------
   localparam logic [7:0] DTM_MFI_EXT_TRIP  = 8'h03;
   localparam logic [7:0] DTM_MFI_OUT_BLOCK = 8'h04;
   localparam int         DTM_MFI_N         = 8;

   // ----------------------------------------------------------------
   // Trip indices
   // ----------------------------------------------------------------
   localparam int DTM_LVL_UNDERVOLT = 0;
   localparam int DTM_LVL_OUT_BLOCK = 1;
   localparam int DTM_LVL_KEYPAD    = 2;
   localparam int DTM_LVL_CMD       = 3;
   localparam int DTM_LVL_OPT1      = 4;
   localparam int DTM_LVL_N         = 7;

   localparam int DTM_LAT_OVERLOAD  = 0;
   localparam int DTM_LAT_UNDERLOAD = 1;
   localparam int DTM_LAT_OVERCUR   = 2;
   localparam int DTM_LAT_OVERVOLT  = 3;
   localparam int DTM_LAT_PH_OUT    = 4;
   localparam int DTM_LAT_PH_IN     = 5;
   localparam int DTM_LAT_INV_THERM = 6;
   localparam int DTM_LAT_MOT_THERM = 7;
   localparam int DTM_LAT_FUSE      = 8;
   localparam int DTM_LAT_EXT       = 9;
   localparam int DTM_LAT_FAN       = 10;
   localparam int DTM_LAT_DEV       = 11;
   localparam int DTM_LAT_ENCODER   = 12;
   localparam int DTM_LAT_OVERSPD   = 13;
   localparam int DTM_LAT_PROCESS   = 14;
   localparam int DTM_LAT_N         = 15;

   localparam int DTM_FAT_N = 4;

   // History entry codes: latch index, fatal codes follow
   localparam logic [4:0] DTM_HIST_FATAL_BASE = 5'h10;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint DTM_CLK_HZ          = 200000000;
   localparam longint DTM_KEYPAD_LOSS_MS  = 2000;
   localparam longint DTM_KEYPAD_LOSS_CYC = DTM_KEYPAD_LOSS_MS * (DTM_CLK_HZ / 1000);
   localparam longint DTM_INV_OL150_MS    = 60000;
   localparam longint DTM_INV_OL150_CYC   = DTM_INV_OL150_MS * (DTM_CLK_HZ / 1000);
   localparam longint DTM_INV_OL200_MS    = 500;
   localparam longint DTM_INV_OL200_CYC   = DTM_INV_OL200_MS * (DTM_CLK_HZ / 1000);

   // Current in percent of rated
   localparam logic [9:0] DTM_PCT_150 = 10'h096;
   localparam logic [9:0] DTM_PCT_200 = 10'h0C8;

endpackage : dtm_pkg

// file: verilog/dtm_history_mem.sv
`timescale 1ns/1ps
module dtm_history_mem
   import dtm_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock only
   input  wire logic         clk_i,
   // Write side
   input  wire logic         wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [4:0]   wr_data_i,
   // Read side
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [4:0]   rd_data_o
);

   logic [4:0] mem_r [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rd_data_o <= mem_r[rd_addr_i];
   end

endmodule : dtm_history_mem

// file: verilog/dtm_trip_manager.sv
`timescale 1ns/1ps
// Operation
// R1: Overload above level latches a trip while overload enable is set.
// R2: Light load within level latches underload trip while enabled.
// R3: Output current above twice rated latches over-current trip.
// R4: Bus undervoltage is a level trip; bus overvoltage latches.
// R5: Phase setting bit 1 enables output, bit 2 input phase loss trips.
// R6: Inverter thermal trip: 1 minute at 150%, 0.5 s at 200%, latched.
// R7: Motor thermal model overheat latches a trip while enabled.
// R8: DC fuse open latches a trip only on ratings above 30kW.
// R9: Input with function code 3 is an external latching trip.
// R10: Input with function code 4 blocks output while asserted.
// R11: Memory, offset or watchdog faults raise a fatal trip.
// R12: Fan fault latches a trip when fan action is 0.
// R13: Speed deviation latches a trip when deviation enable is 1.
// R14: Persistent encoder fault with wire check 1 latches a trip.
// R15: Speed above overspeed level latches a trip.
// R16: Process feedback held low during pre-PID latches a trip.
// R17: Keypad silent 2 s while it commands gives a level trip.
// R18: Non-keypad command fault gives a level trip when enabled.
// R19: Each option slot 1 to 3 has its own level trip.
// R20: Level trips clear with their cause and skip the history.
// R21: Latched trips clear on reset input only after cause is gone.
// R22: Fatal trips ignore reset input; only power cycling clears them.
// R23: Any trip holds output block; latch and fatal trips are logged, one entry per cycle.
// R24: Power-on reset clears trips; a present fatal cause sets again.
module dtm_trip_manager
   import dtm_pkg::*;
#(
   parameter longint KEYPAD_LOSS_CYC = DTM_KEYPAD_LOSS_CYC,
   parameter longint INV_OL150_CYC   = DTM_INV_OL150_CYC,
   parameter longint INV_OL200_CYC   = DTM_INV_OL200_CYC,
   parameter int     HIST_DEPTH      = 16,
   parameter int     HIST_AW         = 4
) (
   // Clock and power-on reset
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   // Register port
   input  wire logic [3:0]            reg_addr_i,
   input  wire logic [31:0]           reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic      [31:0]           reg_rdata_o,
   // Power stage and sensor flags
   input  wire logic                  load_over_level_i,
   input  wire logic                  load_under_level_i,
   input  wire logic [9:0]            current_pct_i,
   input  wire logic                  bus_undervolt_i,
   input  wire logic                  bus_overvolt_i,
   input  wire logic                  out_phase_lost_i,
   input  wire logic                  in_phase_lost_i,
   input  wire logic                  motor_thermal_hot_i,
   input  wire logic                  fuse_open_i,
   input  wire logic                  fan_fault_i,
   input  wire logic                  speed_dev_i,
   input  wire logic                  encoder_fault_persist_i,
   input  wire logic                  overspeed_i,
   input  wire logic                  process_low_persist_i,
   input  wire logic [DTM_FAT_N-1:0]  hw_diag_i,
   // Terminal inputs
   input  wire logic [DTM_MFI_N-1:0]  terminal_i,
   // Keypad, command and option monitors
   input  wire logic                  keypad_cmd_src_i,
   input  wire logic                  keypad_alive_i,
   input  wire logic                  command_fault_i,
   input  wire logic [2:0]            option_lost_i,
   // Trip reset input
   input  wire logic                  trip_reset_i,
   // Outputs
   output logic                       output_block_o,
   output logic                       any_trip_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic mfi_hit(input logic [8*DTM_MFI_N-1:0] sel,
                                    input logic [DTM_MFI_N-1:0]   pins,
                                    input logic [7:0]             code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < DTM_MFI_N; i++) begin
         if (pins[i] && sel[8*i +: 8] == code) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : mfi_hit

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [DTM_CTRL_W-1:0]    ctrl_r;
   logic [8*DTM_MFI_N-1:0]   mfi_sel_r;
   logic [HIST_AW-1:0]       hist_rd_ptr_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_r <= DTM_CTRL_RESET;
      end else if (reg_wr_i && reg_addr_i == DTM_ADDR_CTRL) begin
         ctrl_r <= reg_wdata_i[DTM_CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mfi_sel_r <= '0;
      end else if (reg_wr_i && reg_addr_i == DTM_ADDR_MFI_SEL) begin
         // Four slot codes in the low word; bit 31 picks the upper half, where bits 23:0 load slots 4 to 6 and slot 7 keeps its code
         if (reg_wdata_i[31]) begin
            mfi_sel_r[63:32] <= {8'h00, reg_wdata_i[23:0]} | {mfi_sel_r[63:56], 24'h000000};
         end else begin
            mfi_sel_r[31:0] <= reg_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hist_rd_ptr_r <= '0;
      end else if (reg_wr_i && reg_addr_i == DTM_ADDR_HIST_RD) begin
         hist_rd_ptr_r <= reg_wdata_i[HIST_AW-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Inverter thermal integrator
   // ----------------------------------------------------------------
   // 150% fills the budget in INV_OL150_CYC, 200% and above in INV_OL200_CYC
   localparam longint INV_BUDGET = INV_OL150_CYC * 2;
   logic [39:0] inv_heat_r;
   logic [9:0]  cur_clip;
   logic [39:0] inv_rate;
   logic        inv_therm_hot;

   always_comb begin
      cur_clip = (current_pct_i > DTM_PCT_200) ? DTM_PCT_200 : current_pct_i;
      if (cur_clip > 10'd100) begin
         inv_rate = (cur_clip >= DTM_PCT_200) ?
                    40'(INV_BUDGET / INV_OL200_CYC) :
                    40'(2 * (cur_clip - 10'd100) / 50);
      end else begin
         inv_rate = 40'd0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         inv_heat_r <= '0;
      end else if (inv_rate != 40'd0) begin
         if (inv_heat_r < 40'(INV_BUDGET)) begin
            inv_heat_r <= inv_heat_r + inv_rate; // R6
         end
      end else if (inv_heat_r != 40'd0) begin
         inv_heat_r <= inv_heat_r - 40'd1;
      end
   end

   assign inv_therm_hot = (inv_heat_r >= 40'(INV_BUDGET)); // R6

   // ----------------------------------------------------------------
   // Keypad loss timer
   // ----------------------------------------------------------------
   logic [31:0] kp_cnt_r;
   logic        keypad_lost;

   always_ff @(posedge clk_i) begin
      if (reset_i || keypad_alive_i || !keypad_cmd_src_i) begin
         kp_cnt_r <= '0;
      end else if (kp_cnt_r < 32'(KEYPAD_LOSS_CYC)) begin
         kp_cnt_r <= kp_cnt_r + 32'd1;
      end
   end

   assign keypad_lost = (kp_cnt_r >= 32'(KEYPAD_LOSS_CYC)); // R17

   // ----------------------------------------------------------------
   // Cause vectors
   // ----------------------------------------------------------------
   logic [DTM_LVL_N-1:0] lvl_cause;
   logic [DTM_LAT_N-1:0] lat_cause;

   always_comb begin
      lvl_cause                      = '0;
      lvl_cause[DTM_LVL_UNDERVOLT]   = bus_undervolt_i; // R4
      lvl_cause[DTM_LVL_OUT_BLOCK]   = mfi_hit(mfi_sel_r, terminal_i, DTM_MFI_OUT_BLOCK); // R10
      lvl_cause[DTM_LVL_KEYPAD]      = keypad_lost && ctrl_r[DTM_CTRL_KEYPAD_LOSS]; // R17
      lvl_cause[DTM_LVL_CMD]         = command_fault_i && ctrl_r[DTM_CTRL_CMD_LOSS]; // R18
      lvl_cause[DTM_LVL_OPT1 +: 3]   = option_lost_i; // R19
   end

   always_comb begin
      lat_cause = '0;
      lat_cause[DTM_LAT_OVERLOAD]  = load_over_level_i && ctrl_r[DTM_CTRL_OVERLOAD_EN]; // R1
      lat_cause[DTM_LAT_UNDERLOAD] = load_under_level_i && ctrl_r[DTM_CTRL_UNDERLOAD_EN]; // R2
      lat_cause[DTM_LAT_OVERCUR]   = current_pct_i > DTM_PCT_200; // R3
      lat_cause[DTM_LAT_OVERVOLT]  = bus_overvolt_i; // R4
      lat_cause[DTM_LAT_PH_OUT]    = out_phase_lost_i && ctrl_r[DTM_CTRL_PHASE_OUT]; // R5
      lat_cause[DTM_LAT_PH_IN]     = in_phase_lost_i && ctrl_r[DTM_CTRL_PHASE_IN]; // R5
      lat_cause[DTM_LAT_INV_THERM] = inv_therm_hot; // R6
      lat_cause[DTM_LAT_MOT_THERM] = motor_thermal_hot_i && ctrl_r[DTM_CTRL_THERMAL_EN]; // R7
      lat_cause[DTM_LAT_FUSE]      = fuse_open_i && ctrl_r[DTM_CTRL_FUSE_RATED]; // R8
      lat_cause[DTM_LAT_EXT]       = mfi_hit(mfi_sel_r, terminal_i, DTM_MFI_EXT_TRIP); // R9
      lat_cause[DTM_LAT_FAN]       = fan_fault_i && !ctrl_r[DTM_CTRL_FAN_ACTION]; // R12
      lat_cause[DTM_LAT_DEV]       = speed_dev_i && ctrl_r[DTM_CTRL_DEV_EN]; // R13
      lat_cause[DTM_LAT_ENCODER]   = encoder_fault_persist_i && ctrl_r[DTM_CTRL_WIRE_CHECK]; // R14
      lat_cause[DTM_LAT_OVERSPD]   = overspeed_i; // R15
      lat_cause[DTM_LAT_PROCESS]   = process_low_persist_i; // R16
   end

   // ----------------------------------------------------------------
   // Trip state
   // ----------------------------------------------------------------
   logic [DTM_LVL_N-1:0] lvl_trip_r;
   logic [DTM_LAT_N-1:0] lat_trip_r;
   logic [DTM_FAT_N-1:0] fat_trip_r;
   logic [DTM_LAT_N-1:0] lat_new;
   logic [DTM_FAT_N-1:0] fat_new;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         lvl_trip_r <= '0; // R24
      end else begin
         lvl_trip_r <= lvl_cause; // R20
      end
   end

   // Set wins over clear: a cause still present keeps its bit
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         lat_trip_r <= '0; // R24
      end else if (trip_reset_i) begin
         lat_trip_r <= lat_cause; // R21
      end else begin
         lat_trip_r <= lat_trip_r | lat_cause; // R21
      end
   end

   // Power-on reset is the only clear; cause re-sets it right after
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fat_trip_r <= '0; // R24
      end else begin
         fat_trip_r <= fat_trip_r | hw_diag_i; // R11 R22
      end
   end

   assign lat_new = lat_cause & ~lat_trip_r;
   assign fat_new = hw_diag_i & ~fat_trip_r;

   // ----------------------------------------------------------------
   // Fault history
   // ----------------------------------------------------------------
   // One entry per cycle: of trips raised together only one is logged, a fatal trip over any latch trip, else the lowest index
   logic [HIST_AW-1:0] hist_wr_ptr_r;
   logic [15:0]        hist_cnt_r;
   logic               hist_wr;
   logic [4:0]         hist_code;
   logic [4:0]         hist_rdata;

   always_comb begin
      hist_wr   = 1'b0;
      hist_code = 5'h00;
      for (int i = DTM_FAT_N - 1; i >= 0; i--) begin
         if (fat_new[i]) begin
            hist_wr   = 1'b1;
            hist_code = DTM_HIST_FATAL_BASE + 5'(i);
         end
      end
      for (int i = DTM_LAT_N - 1; i >= 0; i--) begin
         if (lat_new[i] && !(|fat_new)) begin
            hist_wr   = 1'b1;
            hist_code = 5'(i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hist_wr_ptr_r <= '0;
         hist_cnt_r    <= '0;
      end else if (hist_wr) begin
         hist_wr_ptr_r <= hist_wr_ptr_r + HIST_AW'(1); // R23
         hist_cnt_r    <= hist_cnt_r + 16'd1;
      end
   end

   dtm_history_mem #(
      .DEPTH     (HIST_DEPTH),
      .AW        (HIST_AW)
   ) u_hist (
      .clk_i     (clk_i),
      .wr_en_i   (hist_wr),
      .wr_addr_i (hist_wr_ptr_r),
      .wr_data_i (hist_code),
      .rd_addr_i (hist_rd_ptr_r),
      .rd_data_o (hist_rdata)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic trip_any;
   assign trip_any = (|lvl_trip_r) || (|lat_trip_r) || (|fat_trip_r);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         output_block_o <= 1'b0;
         any_trip_o     <= 1'b0;
      end else begin
         output_block_o <= trip_any || (|lvl_cause) || (|lat_cause) || (|hw_diag_i); // R23
         any_trip_o     <= trip_any;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   logic       rd_hist_r;
   logic [3:0] rd_addr_r;
   logic       rd_r;
   logic [31:0] rd_word_r;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_r      <= 1'b0;
         rd_hist_r <= 1'b0;
         rd_addr_r <= 4'h0;
         rd_word_r <= 32'h00000000;
      end else begin
         rd_r      <= reg_rd_i;
         rd_hist_r <= reg_rd_i && reg_addr_i == DTM_ADDR_HIST_RD;
         rd_addr_r <= reg_addr_i;
         case (reg_addr_i)
            DTM_ADDR_CTRL:      rd_word_r <= 32'(ctrl_r);
            DTM_ADDR_LEVEL_STS: rd_word_r <= 32'(lvl_trip_r);
            DTM_ADDR_LATCH_STS: rd_word_r <= 32'(lat_trip_r);
            DTM_ADDR_FATAL_STS: rd_word_r <= 32'(fat_trip_r);
            DTM_ADDR_HIST_CNT:  rd_word_r <= {16'h0000, hist_cnt_r};
            DTM_ADDR_MFI_SEL:   rd_word_r <= mfi_sel_r[31:0];
            default:            rd_word_r <= 32'h00000000;
         endcase
      end
   end

   always_comb begin
      if (!rd_r) begin
         reg_rdata_o = 32'h00000000;
      end else if (rd_hist_r) begin
         reg_rdata_o = {11'h000, rd_addr_r == DTM_ADDR_HIST_RD, 15'h0000, hist_rdata};
      end else begin
         reg_rdata_o = rd_word_r;
      end
   end

endmodule : dtm_trip_manager

// file: bench/dtm_plant_model.sv
`timescale 1ns/1ps
module dtm_plant_model (
   // Clock
   input  wire logic        clk_i,
   // Plant conditions chosen by the bench
   input  wire logic [14:0] fault_i,
   // Sensor flags, bit n feeds latch trip n; bits 2, 6 and 9 are left unconnected
   output logic      [14:0] flag_o
);
   // Comparators settle one cycle late
   always_ff @(posedge clk_i) begin
      flag_o <= fault_i;
   end
endmodule : dtm_plant_model

// file: bench/dtm_trip_manager_asserts.sv
`timescale 1ns/1ps
module dtm_checker
   import dtm_pkg::*;
(
   // Clock and reset
   input wire logic                 clk_i,
   input wire logic                 reset_i,
   // Causes
   input wire logic [9:0]           current_pct_i,
   input wire logic                 bus_undervolt_i,
   input wire logic                 bus_overvolt_i,
   input wire logic [DTM_FAT_N-1:0] hw_diag_i,
   input wire logic                 trip_reset_i,
   // Outputs
   input wire logic                 output_block_o,
   input wire logic                 any_trip_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_fatal_block;
      (hw_diag_i != '0) |-> ##2 output_block_o;
   endproperty
   a_fatal_block: assert property (p_fatal_block) else $error("fatal cause not blocking");
   property p_fatal_hold;
      (hw_diag_i != '0) |-> ##3 any_trip_o [*8];
   endproperty
   a_fatal_hold: assert property (p_fatal_hold) else $error("fatal trip dropped");
   property p_overcur;
      (current_pct_i > DTM_PCT_200) |-> ##2 output_block_o;
   endproperty
   a_overcur: assert property (p_overcur) else $error("over-current not blocking");
   property p_overcur_hold;
      (current_pct_i > DTM_PCT_200) ##1 !trip_reset_i [*4] |-> any_trip_o;
   endproperty
   a_overcur_hold: assert property (p_overcur_hold) else $error("over-current not held");
   property p_undervolt;
      $rose(bus_undervolt_i) |-> ##2 output_block_o;
   endproperty
   a_undervolt: assert property (p_undervolt) else $error("undervoltage not blocking");
   property p_overvolt_hold;
      bus_overvolt_i ##1 !trip_reset_i [*3] |-> output_block_o;
   endproperty
   a_overvolt_hold: assert property (p_overvolt_hold) else $error("overvoltage not held");
   property p_set_wins;
      bus_overvolt_i && trip_reset_i |-> ##3 any_trip_o;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("trip cleared with cause present");
   property p_any_block;
      any_trip_o |-> output_block_o;
   endproperty
   a_any_block: assert property (p_any_block) else $error("trip active without block");
   c_undervolt: cover property (bus_undervolt_i);
   c_fatal: cover property (hw_diag_i != '0);
   c_set_wins: cover property (bus_overvolt_i && trip_reset_i);
endmodule : dtm_checker

bind dtm_trip_manager dtm_checker i_dtm_checker (
   .clk_i(clk_i), .reset_i(reset_i), .current_pct_i(current_pct_i),
   .bus_undervolt_i(bus_undervolt_i), .bus_overvolt_i(bus_overvolt_i),
   .hw_diag_i(hw_diag_i), .trip_reset_i(trip_reset_i),
   .output_block_o(output_block_o), .any_trip_o(any_trip_o));

// file: bench/dtm_trip_manager_tb_top.sv
`timescale 1ns/1ps
module dtm_trip_manager_tb_top;
   import dtm_pkg::*;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [9:0]  current_pct_i = 10'h000;
   logic        bus_undervolt_i = 1'b0;
   logic [3:0]  hw_diag_i = 4'h0;
   logic [7:0]  terminal_i = 8'h00;
   logic        keypad_cmd_src_i = 1'b0;
   logic        keypad_alive_i = 1'b1;
   logic        command_fault_i = 1'b0;
   logic [2:0]  option_lost_i = 3'h0;
   logic        trip_reset_i = 1'b0;
   logic [14:0] fault = 15'h0000;
   logic [14:0] flag;
   logic        output_block_o;
   logic        any_trip_o;
   int          mismatches = 0;
   int          num_checks = 0;
   int          gb[8] = '{0, 1, 2, 3, 4, 6, 7, 10};
   int          gi[8] = '{0, 1, 7, 4, 5, 11, 12, 8};
   always #2.5 clk_i = ~clk_i;
   dtm_plant_model i_dtm_plant_model (.clk_i(clk_i), .fault_i(fault), .flag_o(flag));
   dtm_trip_manager #(.KEYPAD_LOSS_CYC(50), .INV_OL150_CYC(1200), .INV_OL200_CYC(10))
   i_dtm_trip_manager (
      .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .load_over_level_i(flag[0]), .load_under_level_i(flag[1]),
      .current_pct_i(current_pct_i), .bus_undervolt_i(bus_undervolt_i),
      .bus_overvolt_i(flag[3]), .out_phase_lost_i(flag[4]), .in_phase_lost_i(flag[5]),
      .motor_thermal_hot_i(flag[7]), .fuse_open_i(flag[8]), .fan_fault_i(flag[10]),
      .speed_dev_i(flag[11]), .encoder_fault_persist_i(flag[12]), .overspeed_i(flag[13]),
      .process_low_persist_i(flag[14]), .hw_diag_i(hw_diag_i), .terminal_i(terminal_i),
      .keypad_cmd_src_i(keypad_cmd_src_i), .keypad_alive_i(keypad_alive_i),
      .command_fault_i(command_fault_i), .option_lost_i(option_lost_i),
      .trip_reset_i(trip_reset_i), .output_block_o(output_block_o), .any_trip_o(any_trip_o));
   // ----------------------------------------------------------------
   // Bus and control tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i) reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rc(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i) reg_rd_i <= 1'b0;
      #1 chk($sformatf("reg %0h", a), reg_rdata_o, exp);
   endtask : rc
   task automatic pulse_trst();
      @(posedge clk_i) trip_reset_i <= 1'b1;
      @(posedge clk_i) trip_reset_i <= 1'b0;
   endtask : pulse_trst
   task automatic pwr_reset();
      @(posedge clk_i) reset_i <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i) reset_i <= 1'b0;
   endtask : pwr_reset
   // Trip reset with the cause present keeps the trip
   task automatic latch_case(input int idx, input logic [31:0] ctrl, input logic [31:0] exp);
      wr(DTM_ADDR_CTRL, ctrl);
      @(posedge clk_i) fault <= 15'h0001 << idx;
      cyc(3);
      pulse_trst();
      rc(DTM_ADDR_LATCH_STS, exp);
      @(posedge clk_i) fault <= 15'h0000;
      cyc(2);
      pulse_trst();
      rc(DTM_ADDR_LATCH_STS, 32'h0);
   endtask : latch_case
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(2);
      reset_i <= 1'b0;
      for (int a = 0; a < 8; a++) if (a < 5 || a == 7) rc(4'(a), 32'h0);
      @(posedge clk_i) current_pct_i <= DTM_PCT_200;
      cyc(3);
      rc(DTM_ADDR_LATCH_STS, 32'h0);
      cyc(20);
      rc(DTM_ADDR_LATCH_STS, 32'h40);
      @(posedge clk_i) current_pct_i <= 10'h000;
      pwr_reset();
      @(posedge clk_i) current_pct_i <= DTM_PCT_200 + 10'h001;
      @(posedge clk_i) current_pct_i <= 10'h000;
      cyc(2);
      rc(DTM_ADDR_LATCH_STS, 32'h4);
      rc(DTM_ADDR_HIST_CNT, 32'h1);
      wr(DTM_ADDR_HIST_RD, 32'h0);
      rc(DTM_ADDR_HIST_RD, 32'h0010_0002);
      pulse_trst();
      rc(DTM_ADDR_LATCH_STS, 32'h0);
      @(posedge clk_i) bus_undervolt_i <= 1'b1;
      cyc(2);
      rc(DTM_ADDR_LEVEL_STS, 32'h1);
      chk("outputs", {output_block_o, any_trip_o}, 32'h3);
      @(posedge clk_i) bus_undervolt_i <= 1'b0;
      cyc(2);
      rc(DTM_ADDR_LEVEL_STS, 32'h0);
      rc(DTM_ADDR_HIST_CNT, 32'h1);
      for (int k = 0; k < 8; k++) begin
         latch_case(gi[k], 32'h0, 32'h0);
         latch_case(gi[k], 32'h1 << gb[k], 32'h1 << gi[k]);
      end
      latch_case(10, 32'h0, 32'h400);
      latch_case(10, 32'h20, 32'h0);
      latch_case(3, 32'h0, 32'h8);
      latch_case(13, 32'h0, 32'h2000);
      latch_case(14, 32'h0, 32'h4000);
      wr(DTM_ADDR_MFI_SEL, 32'h0000_0403);
      rc(DTM_ADDR_MFI_SEL, 32'h0000_0403);
      @(posedge clk_i) terminal_i <= 8'h01;
      cyc(2);
      rc(DTM_ADDR_LATCH_STS, 32'h200);
      @(posedge clk_i) terminal_i <= 8'h02;
      cyc(2);
      rc(DTM_ADDR_LEVEL_STS, 32'h2);
      @(posedge clk_i) terminal_i <= 8'h00;
      cyc(2);
      rc(DTM_ADDR_LEVEL_STS, 32'h0);
      pulse_trst();
      wr(DTM_ADDR_CTRL, 32'h300);
      @(posedge clk_i) keypad_cmd_src_i <= 1'b1;
      keypad_alive_i <= 1'b0;
      cyc(40);
      rc(DTM_ADDR_LEVEL_STS, 32'h0);
      cyc(20);
      rc(DTM_ADDR_LEVEL_STS, 32'h4);
      @(posedge clk_i) keypad_alive_i <= 1'b1;
      command_fault_i <= 1'b1;
      cyc(2);
      rc(DTM_ADDR_LEVEL_STS, 32'h8);
      @(posedge clk_i) command_fault_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i) option_lost_i <= 3'h1 << i;
         cyc(2);
         rc(DTM_ADDR_LEVEL_STS, 32'h10 << i);
      end
      @(posedge clk_i) option_lost_i <= 3'h0;
      cyc(2);
      rc(DTM_ADDR_LEVEL_STS, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i) hw_diag_i <= 4'h1 << i;
         cyc(3);
         @(posedge clk_i) hw_diag_i <= 4'h0;
         pulse_trst();
         rc(DTM_ADDR_FATAL_STS, 32'h1 << i);
         pwr_reset();
         rc(DTM_ADDR_FATAL_STS, 32'h0);
      end
      @(posedge clk_i) hw_diag_i <= 4'h1;
      pwr_reset();
      cyc(2);
      rc(DTM_ADDR_FATAL_STS, 32'h1);
      complete_run();
   end
endmodule : dtm_trip_manager_tb_top
